// [rtl/flash_program_erase_control.sv]
// Function
// - User-data key register reads back zero
// - Done flag set on completion, write-one clears
// - Protect error on protected address main-flash program
// - Not-erased error when program location not 0xFFFF
// - Busy flag high while operation runs
// - High-protect disable clears user data, self-clears
// - After that reset, user data reports unlocked
// - Done interrupt only with done enable
// - Error interrupt only with error enable
// - Unlocked indicator gates user-data erase/program
// - Writing zero re-locks user data area
// - Operation lock resets one, blocks main ops
// - Valid flash unlock clears operation lock
// - Writing one to operation lock relocks
// - Erase start triggers erase, self-clears after
// - Address register gives the erase target
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_control #(
  parameter logic [31:0] FLASH_KEY_FIRST = 32'h1234_5678, // Arbitrary value
  parameter logic [31:0] FLASH_KEY_SECOND = 32'h9abc_def0, // Arbitrary value
  parameter logic [31:0] USD_KEY_FIRST = 32'h1234_5678, // Arbitrary value
  parameter logic [31:0] USD_KEY_SECOND = 32'h9abc_def0 // Arbitrary value
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] s_awaddr, // AXI write address
  input wire logic s_awvalid, // AXI write address valid
  output logic s_awready, // AXI write address ready
  input wire logic [31:0] s_wdata, // AXI write data
  input wire logic [3:0] s_wstrb, // AXI write strobes
  input wire logic s_wvalid, // AXI write data valid
  output logic s_wready, // AXI write data ready
  output logic [1:0] s_bresp, // AXI write response
  output logic s_bvalid, // AXI write response valid
  input wire logic s_bready, // AXI write response ready
  input wire logic [7:0] s_araddr, // AXI read address
  input wire logic s_arvalid, // AXI read address valid
  output logic s_arready, // AXI read address ready
  output logic [31:0] s_rdata, // AXI read data
  output logic [1:0] s_rresp, // AXI read response
  output logic s_rvalid, // AXI read data valid
  input wire logic s_rready, // AXI read data ready
  input wire logic prog_valid, // Halfword write to flash space
  output logic prog_ready, // Halfword write taken
  input wire logic [31:0] prog_addr, // Target location of the write
  input wire logic [15:0] prog_data, // Halfword to program
  output flash_ctl_pkg::flash_cmd_t arr_cmd, // Command to the array
  output logic arr_req, // Array operation requested
  input wire logic arr_ack, // Array operation finished, pulse
  input wire logic [15:0] arr_rdata, // Content at arr_cmd.addr
  input wire logic arr_protected, // arr_cmd.addr is write protected
  input wire logic usd_unlocked_boot, // User data was cleared before reset
  output logic irq // Combined interrupt, active high
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_RUN} seq_state_t;

  seq_state_t state;
  logic aw_held, w_held;
  logic [7:0] aw_addr_q, rd_addr;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go, wr_en;
  logic [31:0] rd_word;
  logic done_flag, protect_err, not_erased_err;
  logic done_ie, err_ie, op_lock, user_unlocked, erase_start, hp_dis;
  logic [5:0] op_select;
  logic [31:0] erase_target_address;
  logic flash_key_armed, usd_key_armed, boot_seen;
  logic flash_unlock_ok, usd_unlock_ok;
  logic launch, op_finish, check_fail_protect, check_fail_blank, busy;
  flash_ctl_pkg::flash_op_t next_op;
  logic prog_take, erase_abort;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == flash_ctl_pkg::OFF_FLASH_KEY) || (a == flash_ctl_pkg::OFF_USD_KEY)
             || (a == flash_ctl_pkg::OFF_STATUS) || (a == flash_ctl_pkg::OFF_CONTROL)
             || (a == flash_ctl_pkg::OFF_ADDR);
  endfunction : is_mapped

  function automatic logic is_main_op(input flash_ctl_pkg::flash_op_t op);
    is_main_op = (op == flash_ctl_pkg::OP_MAIN_PROG) || (op == flash_ctl_pkg::OP_SECTOR_ERASE)
              || (op == flash_ctl_pkg::OP_BANK_ERASE);
  endfunction : is_main_op

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  // Address and data are caught in either order; the response follows both
  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready = !w_held && !s_bvalid;
  assign wr_go = aw_held && w_held && !s_bvalid;
  // Partial-word writes are refused rather than merged into a register
  assign wr_en = wr_go && is_mapped(aw_addr_q) && (w_strb_q == flash_ctl_pkg::STRB_FULL);

  // Holding registers for the two write channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both channels are held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_bvalid <= 1'b0;
      s_bresp <= flash_ctl_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_en ? flash_ctl_pkg::RESP_OKAY : flash_ctl_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  assign s_arready = !s_rvalid;

  // Read view; key and address registers are write-only and read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_araddr == flash_ctl_pkg::OFF_STATUS) begin
      rd_word[flash_ctl_pkg::STS_DONE] = done_flag;
      rd_word[flash_ctl_pkg::STS_PROTECT] = protect_err;
      rd_word[flash_ctl_pkg::STS_NOT_ERASED] = not_erased_err;
      rd_word[flash_ctl_pkg::STS_BUSY] = busy;
    end else if (s_araddr == flash_ctl_pkg::OFF_CONTROL) begin
      rd_word[flash_ctl_pkg::CTL_HP_DIS] = hp_dis;
      rd_word[flash_ctl_pkg::CTL_DONE_IE] = done_ie;
      rd_word[flash_ctl_pkg::CTL_ERR_IE] = err_ie;
      rd_word[flash_ctl_pkg::CTL_USD_UNLOCKED] = user_unlocked;
      rd_word[flash_ctl_pkg::CTL_OP_LOCK] = op_lock;
      rd_word[flash_ctl_pkg::CTL_ERASE_START] = erase_start;
      rd_word[flash_ctl_pkg::CTL_USD_ERASE:flash_ctl_pkg::CTL_MAIN_PROG] = op_select;
    end
  end

  // Read data registered on the address handshake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= flash_ctl_pkg::RESP_OKAY;
      rd_addr <= 8'h00;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_word;
      s_rresp <= is_mapped(s_araddr) ? flash_ctl_pkg::RESP_OKAY : flash_ctl_pkg::RESP_SLVERR;
      rd_addr <= s_araddr;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Unlock key sequences
  // --------------------------------------------------------------------------
  // A wrong word anywhere disarms the sequence, so a stray write cannot unlock
  assign flash_unlock_ok = wr_en && (aw_addr_q == flash_ctl_pkg::OFF_FLASH_KEY)
                        && flash_key_armed && (w_data_q == FLASH_KEY_SECOND);
  assign usd_unlock_ok = wr_en && (aw_addr_q == flash_ctl_pkg::OFF_USD_KEY)
                      && usd_key_armed && (w_data_q == USD_KEY_SECOND);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_key_armed <= 1'b0;
      usd_key_armed <= 1'b0;
    end else if (wr_en) begin
      if (aw_addr_q == flash_ctl_pkg::OFF_FLASH_KEY) begin
        flash_key_armed <= !flash_key_armed && (w_data_q == FLASH_KEY_FIRST);
      end else if (aw_addr_q == flash_ctl_pkg::OFF_USD_KEY) begin
        usd_key_armed <= !usd_key_armed && (w_data_q == USD_KEY_FIRST);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  // Lock bits: hardware unlocks, software may only relock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_lock <= 1'b1;
    end else if (flash_unlock_ok) begin
      op_lock <= 1'b0;
    end else if (wr_en && (aw_addr_q == flash_ctl_pkg::OFF_CONTROL)
                 && w_data_q[flash_ctl_pkg::CTL_OP_LOCK]) begin
      op_lock <= 1'b1;
    end
  end

  // Boot image of the user data lock is caught at the first edge after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_seen <= 1'b0;
      user_unlocked <= 1'b0;
    end else begin
      boot_seen <= 1'b1;
      if ((!boot_seen && usd_unlocked_boot) || usd_unlock_ok) begin
        user_unlocked <= 1'b1;
      end else if (wr_en && (aw_addr_q == flash_ctl_pkg::OFF_CONTROL)
                   && !w_data_q[flash_ctl_pkg::CTL_USD_UNLOCKED]) begin
        user_unlocked <= 1'b0;
      end
    end
  end

  // Plain fields: read/write selects and enables, write-only erase target
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_ie <= 1'b0;
      err_ie <= 1'b0;
      op_select <= 6'h00;
      erase_target_address <= flash_ctl_pkg::ADDR_RESET;
    end else if (wr_en && (aw_addr_q == flash_ctl_pkg::OFF_CONTROL)) begin
      done_ie <= w_data_q[flash_ctl_pkg::CTL_DONE_IE];
      err_ie <= w_data_q[flash_ctl_pkg::CTL_ERR_IE];
      op_select <= w_data_q[flash_ctl_pkg::CTL_USD_ERASE:flash_ctl_pkg::CTL_MAIN_PROG];
    end else if (wr_en && (aw_addr_q == flash_ctl_pkg::OFF_ADDR)) begin
      erase_target_address <= w_data_q;
    end
  end

  // Self-clearing starts; a new write of one wins over the hardware clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      erase_start <= 1'b0;
      hp_dis <= 1'b0;
    end else begin
      if (wr_en && (aw_addr_q == flash_ctl_pkg::OFF_CONTROL)
          && w_data_q[flash_ctl_pkg::CTL_ERASE_START]) begin
        erase_start <= 1'b1;
      end else if (erase_abort || (op_finish && arr_cmd.op != flash_ctl_pkg::OP_USD_CLEAR
                   && arr_cmd.op != flash_ctl_pkg::OP_MAIN_PROG
                   && arr_cmd.op != flash_ctl_pkg::OP_USD_PROG)) begin
        erase_start <= 1'b0;
      end
      if (wr_en && (aw_addr_q == flash_ctl_pkg::OFF_CONTROL)
          && w_data_q[flash_ctl_pkg::CTL_HP_DIS]) begin
        hp_dis <= 1'b1;
      end else if (op_finish && arr_cmd.op == flash_ctl_pkg::OP_USD_CLEAR) begin
        hp_dis <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Operation launch decode
  // --------------------------------------------------------------------------
  // Priority: protection disable, then erase, then a pending halfword write
  always_comb begin
    next_op = flash_ctl_pkg::OP_NONE;
    erase_abort = 1'b0;
    prog_take = 1'b0;
    if (state == ST_IDLE && !op_finish) begin
      if (hp_dis) begin
        next_op = flash_ctl_pkg::OP_USD_CLEAR;
      end else if (erase_start) begin
        if (op_select[flash_ctl_pkg::CTL_USD_ERASE] && user_unlocked) begin
          next_op = flash_ctl_pkg::OP_USD_ERASE;
        end else if (op_select[flash_ctl_pkg::CTL_SECTOR] && !op_lock) begin
          next_op = flash_ctl_pkg::OP_SECTOR_ERASE;
        end else if ((op_select[flash_ctl_pkg::CTL_BANK] || op_select[flash_ctl_pkg::CTL_BLOCK])
                     && !op_lock) begin
          next_op = flash_ctl_pkg::OP_BANK_ERASE;
        end else begin
          erase_abort = 1'b1; // Blocked or nothing selected: drop it
        end
      end else if (prog_valid) begin
        prog_take = op_select[flash_ctl_pkg::CTL_MAIN_PROG]
                 || op_select[flash_ctl_pkg::CTL_USD_PROG];
        if (op_select[flash_ctl_pkg::CTL_USD_PROG] && user_unlocked) begin
          next_op = flash_ctl_pkg::OP_USD_PROG;
        end else if (op_select[flash_ctl_pkg::CTL_MAIN_PROG] && !op_lock) begin
          next_op = flash_ctl_pkg::OP_MAIN_PROG;
        end
      end
    end
  end

  // Writes without a program select stall the requester; locked ones are dropped
  assign prog_ready = prog_take;
  assign launch = next_op != flash_ctl_pkg::OP_NONE;
  assign op_finish = (state == ST_RUN) && arr_ack;
  assign arr_req = state == ST_RUN;
  assign busy = state != ST_IDLE;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Programs pass a check cycle: protection first, then the blank check
  assign check_fail_protect = (state == ST_CHECK) && arr_protected
                           && (arr_cmd.op == flash_ctl_pkg::OP_MAIN_PROG);
  assign check_fail_blank = (state == ST_CHECK) && !check_fail_protect
                         && (arr_rdata != flash_ctl_pkg::ERASED_HALFWORD);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      arr_cmd <= '{op: flash_ctl_pkg::OP_NONE, addr: flash_ctl_pkg::ADDR_RESET, data: 16'h0000};
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            arr_cmd.op <= next_op;
            arr_cmd.addr <= prog_take ? prog_addr : erase_target_address;
            arr_cmd.data <= prog_take ? prog_data : flash_ctl_pkg::ERASED_HALFWORD;
            state <= prog_take ? ST_CHECK : ST_RUN;
          end
        end
        ST_CHECK: begin
          state <= (check_fail_protect || check_fail_blank) ? ST_IDLE : ST_RUN;
        end
        ST_RUN: begin
          if (arr_ack) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Status flags and interrupt
  // --------------------------------------------------------------------------
  // Write-one-to-clear; a setting event in the same cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_flag <= 1'b0;
      protect_err <= 1'b0;
      not_erased_err <= 1'b0;
    end else begin
      done_flag <= op_finish || (done_flag && !(wr_en && aw_addr_q == flash_ctl_pkg::OFF_STATUS
                   && w_data_q[flash_ctl_pkg::STS_DONE]));
      protect_err <= check_fail_protect || (protect_err && !(wr_en
                     && aw_addr_q == flash_ctl_pkg::OFF_STATUS
                     && w_data_q[flash_ctl_pkg::STS_PROTECT]));
      not_erased_err <= check_fail_blank || (not_erased_err && !(wr_en
                        && aw_addr_q == flash_ctl_pkg::OFF_STATUS
                        && w_data_q[flash_ctl_pkg::STS_NOT_ERASED]));
    end
  end

  // One line for both sources, each gated by its own enable
  assign irq = (done_flag && done_ie) || ((protect_err || not_erased_err) && err_ie);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_key_reads_zero: assert property (
    (s_arvalid && s_arready && s_araddr == flash_ctl_pkg::OFF_USD_KEY)
      |=> s_rvalid && s_rdata == 32'h0000_0000)
    else $error("user data key register read back nonzero");

  a_done_on_finish: assert property (
    op_finish |=> done_flag && !busy && state == ST_IDLE)
    else $error("done flag not set after array acknowledge");

  a_protect_error: assert property (
    check_fail_protect |=> protect_err && !arr_req && state == ST_IDLE)
    else $error("protected program did not raise error or went on");

  a_blank_error: assert property (
    check_fail_blank |=> not_erased_err && !arr_req && state == ST_IDLE)
    else $error("non-erased target did not raise error");

  a_busy_span: assert property (
    arr_req |-> busy ##1 (busy || $past(op_finish)))
    else $error("busy low while array operation runs");

  a_hp_self_clear: assert property (
    (op_finish && arr_cmd.op == flash_ctl_pkg::OP_USD_CLEAR
     && !(wr_en && aw_addr_q == flash_ctl_pkg::OFF_CONTROL)) |=> !hp_dis)
    else $error("protection disable bit did not clear itself");

  a_done_irq_gate: assert property (
    (!done_ie && !err_ie) |-> !irq)
    else $error("interrupt raised with both enables off");

  a_err_irq: assert property (
    ((protect_err || not_erased_err) && err_ie) |-> irq)
    else $error("error interrupt missing while enabled");

  a_usd_unlock_gate: assert property (
    (state == ST_IDLE && (next_op == flash_ctl_pkg::OP_USD_ERASE
     || next_op == flash_ctl_pkg::OP_USD_PROG)) |-> user_unlocked)
    else $error("user data operation launched while locked");

  a_usd_relock: assert property (
    (wr_en && aw_addr_q == flash_ctl_pkg::OFF_CONTROL && !usd_unlock_ok
     && !w_data_q[flash_ctl_pkg::CTL_USD_UNLOCKED] && boot_seen) |=> !user_unlocked)
    else $error("user data area not re-locked by write of zero");

  a_main_lock_gate: assert property (
    $rose(arr_req) && is_main_op(arr_cmd.op) |-> !$past(op_lock, 2) || !$past(op_lock))
    else $error("main flash operation launched while locked");

  a_unlock_clears: assert property (
    flash_unlock_ok |=> !op_lock)
    else $error("operation lock still set after valid key sequence");

  a_relock: assert property (
    (wr_en && aw_addr_q == flash_ctl_pkg::OFF_CONTROL && w_data_q[flash_ctl_pkg::CTL_OP_LOCK])
      |=> op_lock)
    else $error("operation lock not set by write of one");

  a_erase_clear: assert property (
    (op_finish && (arr_cmd.op == flash_ctl_pkg::OP_SECTOR_ERASE
     || arr_cmd.op == flash_ctl_pkg::OP_BANK_ERASE)
     && !(wr_en && aw_addr_q == flash_ctl_pkg::OFF_CONTROL)) |=> !erase_start)
    else $error("erase start not cleared after erase");

  c_main_program: cover property (
    $rose(arr_req) && arr_cmd.op == flash_ctl_pkg::OP_MAIN_PROG ##[1:20] op_finish);
  c_sector_erase: cover property (
    op_finish && arr_cmd.op == flash_ctl_pkg::OP_SECTOR_ERASE);
  c_protect_fail: cover property (check_fail_protect ##1 irq);
  c_usd_clear: cover property (op_finish && arr_cmd.op == flash_ctl_pkg::OP_USD_CLEAR);

endmodule : flash_program_erase_control

`default_nettype wire

// [rtl/flash_ctl_pkg.sv]
package flash_ctl_pkg;

  // --------------------------------------------------------------------------
  // Register map (byte offsets) and bus responses
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFF_FLASH_KEY = 8'h04;
  localparam logic [7:0] OFF_USD_KEY = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_ADDR = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_FULL = 4'hf;

  // --------------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------------
  localparam int STS_BUSY = 0;
  localparam int STS_NOT_ERASED = 2;
  localparam int STS_PROTECT = 4;
  localparam int STS_DONE = 5;
  localparam int CTL_MAIN_PROG = 0;
  localparam int CTL_SECTOR = 1;
  localparam int CTL_BANK = 2;
  localparam int CTL_BLOCK = 3;
  localparam int CTL_USD_PROG = 4;
  localparam int CTL_USD_ERASE = 5;
  localparam int CTL_ERASE_START = 6;
  localparam int CTL_OP_LOCK = 7;
  localparam int CTL_USD_UNLOCKED = 9;
  localparam int CTL_ERR_IE = 10;
  localparam int CTL_DONE_IE = 12;
  localparam int CTL_HP_DIS = 16;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [15:0] ERASED_HALFWORD = 16'hffff;

  // --------------------------------------------------------------------------
  // Operations and the command handed to the array
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_MAIN_PROG, OP_SECTOR_ERASE, OP_BANK_ERASE,
    OP_USD_PROG, OP_USD_ERASE, OP_USD_CLEAR
  } flash_op_t;

  typedef struct packed {
    flash_op_t op;
    logic [31:0] addr;
    logic [15:0] data;
  } flash_cmd_t;

endpackage : flash_ctl_pkg

// [testbench/flash_array_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------
// Flash array stand-in
// ---------------------------------
module flash_array_model (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire flash_ctl_pkg::flash_cmd_t arr_cmd, // Command
  input wire logic arr_req, // Request level
  input wire logic [3:0] dly, // Ack delay
  output logic arr_ack, // Done pulse
  output logic [15:0] arr_rdata, // Cell content
  output logic arr_protected // Cell protected
);
  logic [3:0] cnt;
  // Address bit 8 marks used cells, bit 9 protected ones
  assign arr_rdata = arr_cmd.addr[8] ? 16'h0000 : 16'hffff;
  assign arr_protected = arr_cmd.addr[9];
  // One pulse only, so a slow answer never finishes twice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      arr_ack <= 1'b0;
    end else begin
      arr_ack <= arr_req && !arr_ack && cnt == dly;
      cnt <= (arr_req && !arr_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : flash_array_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_top;
  logic clk = 0, rst = 1, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
  logic s_rready = 0, prog_valid = 0, boot = 0, s_awready, s_wready, s_bvalid;
  logic s_arready, s_rvalid, prog_ready, arr_req, arr_ack, arr_protected, irq;
  logic [7:0] s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, prog_addr = 0, d;
  logic [15:0] arr_rdata;
  logic [3:0] dly = 4'h1;
  logic [3:0] s_wstrb = 4'hf;
  logic [1:0] s_bresp, s_rresp, r;
  flash_ctl_pkg::flash_cmd_t arr_cmd;
  int err_count = 0, checks = 0, cyc = 0;
  localparam logic [7:0] CTL = flash_ctl_pkg::OFF_CONTROL, STS = flash_ctl_pkg::OFF_STATUS;
  localparam logic [31:0] K1 = 32'h1234_5678, K2 = 32'h9abc_def0;
  flash_program_erase_control u_dut (.clk, .rst, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata(d), .s_rresp,
    .s_rvalid, .s_rready, .prog_valid, .prog_ready, .prog_addr, .prog_data(16'h1234),
    .arr_cmd, .arr_req, .arr_ack, .arr_rdata, .arr_protected, .usd_unlocked_boot(boot), .irq);
  flash_array_model u_arr (.clk, .rst, .arr_cmd, .arr_req, .dly, .arr_ack, .arr_rdata,
    .arr_protected);
  // Free-running clock
  initial forever #2.5 clk = ~clk;
  // Hang guard
  always @(posedge clk) if (++cyc == 20000) begin err_count++; results(); end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_awaddr <= a; s_wdata <= v; s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
    do begin @(posedge clk); if (s_awready) s_awvalid <= 0; if (s_wready) s_wvalid <= 0; end
    while (!s_bvalid);
    r = s_bresp; s_bready <= 0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
    do begin @(posedge clk); if (s_arready) s_arvalid <= 0; end while (!s_rvalid);
    r = s_rresp; s_rready <= 0;
    @(posedge clk);
  endtask : rd
  task automatic idle;
    do rd(STS); while (d[0] !== 1'b0);
  endtask : idle
  task automatic pg(input logic [31:0] a);
    prog_addr <= a; prog_valid <= 1;
    do @(posedge clk); while (!prog_ready);
    prog_valid <= 0; idle;
  endtask : pg
  task automatic t_regs;
    rd(CTL); `CHK(d, 32'h80)
    wr(8'h08, 32'h5a5a_5a5a); rd(8'h08); `CHK(d, 32'h0)
    rd(8'h40); `CHK(r, flash_ctl_pkg::RESP_SLVERR)
    s_wstrb <= 4'h3; wr(CTL, 32'h1000); `CHK(r, flash_ctl_pkg::RESP_SLVERR)
    s_wstrb <= 4'hf; rd(CTL); `CHK(d, 32'h80)
    wr(8'h40, 32'h0); `CHK(r, flash_ctl_pkg::RESP_SLVERR)
    $display("test regs done");
  endtask : t_regs
  task automatic t_erase;
    wr(CTL, 32'h42); idle; rd(CTL); `CHK(d, 32'h82)
    wr(8'h04, K1); wr(8'h04, K2); rd(CTL); `CHK(d, 32'h02)
    dly <= 4'h8; wr(8'h14, 32'h3000); wr(CTL, 32'h1042); rd(STS); `CHK(d, 32'h1)
    `CHK(arr_cmd.addr, 32'h3000)
    `CHK(arr_cmd.op, flash_ctl_pkg::OP_SECTOR_ERASE)
    idle; `CHK(d, 32'h20)
    rd(CTL); `CHK(d, 32'h1002)
    `CHK(irq, 1'b1)
    wr(STS, 32'h20); rd(STS); `CHK({d, irq}, 33'h0)
    for (int i = 2; i < 4; i++) begin
      wr(CTL, 32'h40 | (32'h1 << i)); rd(STS); `CHK(arr_cmd.op, flash_ctl_pkg::OP_BANK_ERASE)
      idle;
    end
    $display("test erase done");
  endtask : t_erase
  task automatic t_prog;
    dly <= 4'h0; wr(STS, 32'h20); wr(CTL, 32'h401); pg(32'h0); `CHK({d, irq}, 33'h40)
    wr(STS, 32'h20); pg(32'h100); `CHK({d, irq}, 33'h9)
    wr(STS, 32'h4); pg(32'h200); `CHK(d, 32'h10)
    `CHK(irq, 1'b1)
    wr(STS, 32'h10); wr(CTL, 32'h81); pg(32'h0); `CHK(d, 32'h0)
    $display("test program done");
  endtask : t_prog
  task automatic t_usd;
    wr(CTL, 32'h10); pg(32'h0); `CHK(d, 32'h0)
    wr(8'h08, K1); wr(8'h08, K2); wr(CTL, 32'h210); pg(32'h0); `CHK(d, 32'h20)
    wr(STS, 32'h20); wr(CTL, 32'h260); idle; `CHK(d, 32'h20)
    `CHK(arr_cmd.op, flash_ctl_pkg::OP_USD_ERASE)
    wr(STS, 32'h20); wr(CTL, 32'h0); rd(CTL); `CHK(d[9], 1'b0)
    wr(CTL, 32'h1_0000); idle; rd(CTL); `CHK(d[16], 1'b0)
    rst <= 1; boot <= 1; repeat (8) @(posedge clk);
    rst <= 0; @(posedge clk); rd(CTL); `CHK(d, 32'h280)
    $display("test user data done");
  endtask : t_usd
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0; t_regs; t_erase; t_prog; t_usd; results();
  end
endmodule : tb_top
`default_nettype wire
